/* src/blc_pkg.sv */
// Purpose: shared constants and carriers of the backlight fault/irq/config block
// Assumes: one 20 MHz clock, asynchronous active-high reset
// Notes: register offsets are byte pointers as seen by the two-wire host port
package blc_pkg;

	// ------------------------------------------------------------
	// clock and serial port
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary neutral address
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h02;
	localparam logic [7:0] OFS_EVENT_IRQ_MASK = 8'h03;
	localparam logic [7:0] OFS_BACKLIGHT_CFG = 8'h04;

	// ------------------------------------------------------------
	// event flag and mask bit positions (same in both registers)
	// ------------------------------------------------------------
	localparam int BIT_SHORT = 4;
	localparam int BIT_THERMAL = 3;
	localparam int BIT_OVERVOLT = 2;
	localparam int BIT_SECOND_LIGHT = 1;
	localparam int BIT_MAIN_LIGHT = 0;
	localparam int EVENT_W = 5;

	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int BIT_SOURCE_SEL = 6;
	localparam int BIT_SECOND_EN = 5;
	localparam int BIT_LEVEL_HI = 4;
	localparam int BIT_LEVEL_LO = 3;
	localparam int BIT_LAW_HI = 2;
	localparam int BIT_FADE_OVR = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [4:0] RST_MASK = 5'h00;
	localparam logic [7:0] RST_CFG = 8'h00;

	// brightness level codes
	typedef enum logic [1:0] {
		BLC_LVL_DAYLIGHT = 2'h0,
		BLC_LVL_OFFICE = 2'h1,
		BLC_LVL_DARK = 2'h2,
		BLC_LVL_OFF = 2'h3
	} blc_level_e;

	// register write strobe with its pointer and data
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} blc_wr_s;

	// hardware event pulses
	typedef struct packed {
		logic short_fault;
		logic thermal_trip;
		logic overvoltage;
		logic second_light;
		logic main_light;
	} blc_event_s;

endpackage : blc_pkg

/* src/blc_regs.sv */
// Purpose: status, interrupt mask and backlight configuration registers
// Assumes: write strobes and events are one-cycle pulses on clk
// Notes: read data is a combinational mux; reads have no side effect
`timescale 1ns/10ps
module blc_regs import blc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register access
	input wire blc_wr_s wr_req,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// hardware side
	input wire blc_event_s events,
	input wire logic auto_light_control_enable,
	input wire logic [1:0] main_sensor_level,
	input wire logic [1:0] second_sensor_level,
	// outputs, all registered
	output logic host_irq_q,
	output logic light_source_select_q,
	output logic second_sensor_enable_q,
	output logic sixth_led_sink_off_q,
	output logic [1:0] brightness_level_q,
	output logic backlight_off_q
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [4:0] flags_q, flags_d, mask_q, set_vec, clr_vec;
	logic [2:0] law_fade_q;
	logic [1:0] level_d, auto_level;
	logic wr_status, wr_mask, wr_cfg;

	assign wr_status = wr_req.wr && (wr_req.addr == OFS_EVENT_STATUS);
	assign wr_mask = wr_req.wr && (wr_req.addr == OFS_EVENT_IRQ_MASK);
	assign wr_cfg = wr_req.wr && (wr_req.addr == OFS_BACKLIGHT_CFG);

	// the second comparator event counts only when the second sensor is enabled; main_light always counts
	assign set_vec = {events.short_fault, events.thermal_trip, events.overvoltage,
		events.second_light && second_sensor_enable_q, events.main_light};
	// write one clears; writing zero leaves the flag alone
	assign clr_vec = wr_status ? wr_req.wdata[EVENT_W-1:0] : 5'h00;
	// a new event in the clearing cycle survives
	assign flags_d = set_vec | (flags_q & ~clr_vec);

	// automatic control follows the selected comparator
	assign auto_level = light_source_select_q ? second_sensor_level
		: main_sensor_level;
	assign level_d = auto_light_control_enable ? auto_level
		: (wr_cfg ? wr_req.wdata[BIT_LEVEL_HI:BIT_LEVEL_LO] : brightness_level_q);

	// ------------------------------------------------------------
	// event flags and host interrupt
	// ------------------------------------------------------------
	// irq is built from next flag values so it lines up with the flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q <= RST_FLAGS;
			host_irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			host_irq_q <= |(flags_d & mask_q);
		end
	end

	// interrupt mask, bits 7:5 are not stored
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= wr_req.wdata[EVENT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// backlight configuration
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			light_source_select_q <= RST_CFG[BIT_SOURCE_SEL];
			second_sensor_enable_q <= RST_CFG[BIT_SECOND_EN];
			sixth_led_sink_off_q <= RST_CFG[BIT_SECOND_EN];
			law_fade_q <= RST_CFG[BIT_LAW_HI:BIT_FADE_OVR];
		end else if (wr_cfg) begin
			light_source_select_q <= wr_req.wdata[BIT_SOURCE_SEL];
			second_sensor_enable_q <= wr_req.wdata[BIT_SECOND_EN];
			sixth_led_sink_off_q <= wr_req.wdata[BIT_SECOND_EN];
			law_fade_q <= wr_req.wdata[BIT_LAW_HI:BIT_FADE_OVR];
		end
	end

	// level field and its zero-current decode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			brightness_level_q <= RST_CFG[BIT_LEVEL_HI:BIT_LEVEL_LO];
			backlight_off_q <= (RST_CFG[BIT_LEVEL_HI:BIT_LEVEL_LO] == BLC_LVL_OFF);
		end else begin
			brightness_level_q <= level_d;
			backlight_off_q <= (level_d == BLC_LVL_OFF);
		end
	end

	// ------------------------------------------------------------
	// read mux, reserved bits read as zero
	// ------------------------------------------------------------
	assign rd_data = (rd_addr == OFS_EVENT_STATUS) ? {3'h0, flags_q}
		: (rd_addr == OFS_EVENT_IRQ_MASK) ? {3'h0, mask_q}
		: (rd_addr == OFS_BACKLIGHT_CFG) ? {1'b0, light_source_select_q,
			second_sensor_enable_q, brightness_level_q, law_fade_q}
		: 8'h00;

endmodule : blc_regs

/* src/blc_fault_irq_cfg.sv */
// Purpose: two-wire host port plus event/mask/config registers of the backlight driver
// Assumes: scl and sda inputs already synchronous to clk, clk far faster than scl
// Notes: data pin is open drain; only the low level is ever driven
`timescale 1ns/10ps

module blc_fault_irq_cfg import blc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// two-wire host port
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_q,
	output logic sda_oe_q,
	// hardware events and comparator results
	input wire blc_event_s events,
	input wire logic auto_light_control_enable,
	input wire logic [1:0] main_sensor_level,
	input wire logic [1:0] second_sensor_level,
	// backlight controls
	output logic host_irq_q,
	output logic light_source_select_q,
	output logic second_sensor_enable_q,
	output logic sixth_led_sink_off_q,
	output logic [1:0] brightness_level_q,
	output logic backlight_off_q
);

	// ------------------------------------------------------------
	// serial engine state
	// ------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACK_ADDR = 9'h004,
		ST_PTR = 9'h008,
		ST_ACK_PTR = 9'h010,
		ST_WDATA = 9'h020,
		ST_ACK_W = 9'h040,
		ST_RDATA = 9'h080,
		ST_ACK_R = 9'h100
	} blc_port_e;

	blc_port_e st_q;
	logic scl_q, sda_q, rw_q;
	logic [7:0] shift_q, ptr_q, rd_data;
	logic [3:0] cnt_q;
	blc_wr_s wr_q;

	// ------------------------------------------------------------
	// line event decode
	// ------------------------------------------------------------
	logic scl_rise, scl_fall, bus_start, bus_stop, byte_full, addr_hit;
	logic [7:0] shift_in;

	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	// data moving while the clock is high marks frame boundaries
	assign bus_start = scl_in && scl_q && sda_q && !sda_in;
	assign bus_stop = scl_in && scl_q && !sda_q && sda_in;
	assign byte_full = (cnt_q == BITS_PER_BYTE);
	assign shift_in = {shift_q[6:0], sda_in};
	assign addr_hit = (shift_q[7:1] == DEV_ADDR);

	// previous line levels, used for edge and frame detection
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_out_q <= 1'b0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			sda_out_q <= 1'b0; // open drain: only low is driven
		end
	end

	// ------------------------------------------------------------
	// byte engine
	// ------------------------------------------------------------
	// data changes only on falling scl so the host samples stable bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			rw_q <= 1'b0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
			wr_q <= '0;
		end else begin
			wr_q.wr <= 1'b0;
			if (bus_start) begin
				st_q <= ST_ADDR; // pointer kept for repeated-start reads
				cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (bus_stop) begin
				st_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (st_q)
					ST_ADDR, ST_PTR, ST_WDATA: begin
						if (scl_rise && !byte_full) begin
							shift_q <= shift_in;
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && byte_full) begin
							if (st_q == ST_ADDR) begin
								// foreign address: stay off the line until next start
								st_q <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
								sda_oe_q <= addr_hit;
								rw_q <= shift_q[0];
							end else if (st_q == ST_PTR) begin
								ptr_q <= shift_q;
								sda_oe_q <= 1'b1;
								st_q <= ST_ACK_PTR;
							end else begin
								wr_q.wr <= 1'b1;
								wr_q.addr <= ptr_q;
								wr_q.wdata <= shift_q;
								sda_oe_q <= 1'b1;
								st_q <= ST_ACK_W;
							end
						end
					end
					ST_ACK_ADDR: begin
						// a read puts its first bit out on the fall that ends the ack
						if (scl_fall) begin
							if (rw_q) begin
								shift_q <= rd_data;
								sda_oe_q <= !rd_data[7];
								cnt_q <= 4'h1;
								st_q <= ST_RDATA;
							end else begin
								sda_oe_q <= 1'b0;
								cnt_q <= 4'h0;
								st_q <= ST_PTR;
							end
						end
					end
					ST_ACK_PTR, ST_ACK_W: begin
						if (scl_fall) begin
							sda_oe_q <= 1'b0;
							cnt_q <= 4'h0;
							if (st_q == ST_ACK_W) begin
								ptr_q <= ptr_q + 8'h01; // burst writes walk the map
							end
							st_q <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						// the ninth clock belongs to the host, so the line is let go first
						if (scl_fall) begin
							if (byte_full) begin
								sda_oe_q <= 1'b0;
								ptr_q <= ptr_q + 8'h01;
								st_q <= ST_ACK_R;
							end else begin
								sda_oe_q <= !shift_q[6];
								shift_q <= {shift_q[6:0], 1'b0};
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					ST_ACK_R: begin
						// a host ack fetches the next byte from the walked pointer
						if (scl_rise && sda_in) begin
							st_q <= ST_IDLE; // host said no more bytes
						end else if (scl_fall) begin
							shift_q <= rd_data;
							sda_oe_q <= !rd_data[7];
							cnt_q <= 4'h1;
							st_q <= ST_RDATA;
						end
					end
					default: begin
						st_q <= ST_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------
	// writes reach the bank only as a one-cycle pulse at the ack,
	// so a byte cut short by a stop never lands
	blc_regs blc_regs_i (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_req(wr_q),
		.rd_addr(ptr_q),
		.rd_data(rd_data),
		.events(events),
		.auto_light_control_enable(auto_light_control_enable),
		.main_sensor_level(main_sensor_level),
		.second_sensor_level(second_sensor_level),
		.host_irq_q(host_irq_q),
		.light_source_select_q(light_source_select_q),
		.second_sensor_enable_q(second_sensor_enable_q),
		.sixth_led_sink_off_q(sixth_led_sink_off_q),
		.brightness_level_q(brightness_level_q),
		.backlight_off_q(backlight_off_q)
	);

endmodule : blc_fault_irq_cfg

/* dv/blc_chk_chk.sv */
// Purpose: port-level assertions for the backlight register block
// Assumes: one clock, asynchronous active-high reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/10ps
module blc_chk import blc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial port
	input wire logic scl_in,
	input wire logic sda_out_q,
	input wire logic sda_oe_q,
	// hardware side
	input wire blc_event_s events,
	input wire logic auto_light_control_enable,
	input wire logic [1:0] main_sensor_level,
	input wire logic [1:0] second_sensor_level,
	// outputs
	input wire logic host_irq_q,
	input wire logic light_source_select_q,
	input wire logic second_sensor_enable_q,
	input wire logic sixth_led_sink_off_q,
	input wire logic [1:0] brightness_level_q,
	input wire logic backlight_off_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// level the comparator path would pick
	wire [1:0] sel_lvl = light_source_select_q ? second_sensor_level : main_sensor_level;
	// registers may only move while the device acks a written byte
	sequence no_write;
		!$past(sda_oe_q);
	endsequence
	// a started ack must hold for the four clocks that follow its first
	sequence ack_held;
		sda_oe_q [*4];
	endsequence
	sink_follow_a: assert property (sixth_led_sink_off_q == second_sensor_enable_q)
		else $error("sixth sink not tied to second sensor enable");
	off_level_a: assert property (backlight_off_q == (brightness_level_q == 2'h3))
		else $error("backlight off flag disagrees with level");
	auto_level_a: assert property ($past(auto_light_control_enable) |->
		brightness_level_q == $past(sel_lvl)) else $error("level not following comparator");
	level_hold_a: assert property (no_write ##0 !$past(auto_light_control_enable)
		|-> $stable(brightness_level_q)) else $error("level moved without cause");
	cfg_hold_a: assert property (no_write |->
		$stable({light_source_select_q, second_sensor_enable_q})) else $error("cfg moved");
	irq_rise_a: assert property ($rose(host_irq_q) |->
		$past(|events) || $past(sda_oe_q)) else $error("interrupt rose without event");
	irq_fall_a: assert property ($fell(host_irq_q) |-> $past(sda_oe_q))
		else $error("interrupt fell without host write");
	ack_start_a: assert property ($rose(sda_oe_q) |-> !scl_in ##1 ack_held)
		else $error("ack not started in clock low or too short");
	line_still_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_q))
		else $error("data line moved while clock high");
	open_drain_a: assert property (sda_out_q == 1'b0)
		else $error("data pin driven high");
endmodule : blc_chk

bind blc_fault_irq_cfg blc_chk blc_chk_i (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in),
	.sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .events(events),
	.auto_light_control_enable(auto_light_control_enable),
	.main_sensor_level(main_sensor_level), .second_sensor_level(second_sensor_level),
	.host_irq_q(host_irq_q), .light_source_select_q(light_source_select_q),
	.second_sensor_enable_q(second_sensor_enable_q),
	.sixth_led_sink_off_q(sixth_led_sink_off_q),
	.brightness_level_q(brightness_level_q), .backlight_off_q(backlight_off_q));

/* dv/blc_host.sv */
// Purpose: host processor model on the two-wire register port
// Assumes: lines change 1 ns after a clock edge, 4 clocks per clock phase
// Notes: only pulls the data line low; a missing device ack is counted
`timescale 1ns/10ps
module blc_host import blc_pkg::*; (
	// clock
	input wire logic clk,
	// resolved data line
	input wire logic sda_in,
	// host-driven lines
	output logic scl,
	output logic sda_pull
);
	int nacks = 0;
	// idle bus: both lines high
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// one clock phase
	task automatic phase();
		repeat (4) @(posedge clk);
		#1;
	endtask : phase
	// one bit, line sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic r);
		sda_pull = !b;
		phase();
		scl = 1'b1;
		phase();
		r = sda_in;
		scl = 1'b0;
		phase();
	endtask : bit_x
	// start, also used as repeated start
	task automatic start();
		sda_pull = 1'b0;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b1;
		phase();
		scl = 1'b0;
		phase();
	endtask : start
	// stop, leaves the bus idle
	task automatic stop();
		sda_pull = 1'b1;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b0;
		phase();
	endtask : stop
	// byte msb first, m is what the host puts on the ninth clock
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(m, a);
	endtask : xfer
	// register write: address, pointer, data
	task automatic wr_reg(input logic [7:0] p, input logic [7:0] v);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		xfer(v, 1'b1, q, a2);
		stop();
		nacks += int'(a0 | a1 | a2);
	endtask : wr_reg
	// register read: pointer, repeated start, one byte closed by a nack
	task automatic rd_reg(input logic [7:0] p, output logic [7:0] v);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, q, a2);
		xfer(8'hff, 1'b1, v, a3);
		stop();
		nacks += int'(a0 | a1 | a2);
	endtask : rd_reg
endmodule : blc_host

/* dv/blc_fault_irq_cfg_test.sv */
// Purpose: self-checking bench of the backlight register block
// Assumes: host model on the serial port, 20 MHz clock
// Notes: expectations come from the register map constants only
`timescale 1ns/10ps
module blc_fault_irq_cfg_test import blc_pkg::*; ();
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic auto = 1'b0;
	logic [1:0] ml = 2'h0;
	logic [1:0] sl = 2'h0;
	blc_event_s ev = '0;
	logic scl, sda_pull, sda_out_q, sda_oe_q, irq, sel, sen, sink, boff;
	logic [1:0] lvl;
	int n_fail = 0;
	int samples_checked = 0;
	// open-drain line with pull-up
	wire sda = !sda_pull & (sda_oe_q ? sda_out_q : 1'b1);
	// 50 ns clock
	always #25 clk = !clk;
	blc_fault_irq_cfg blc_fault_irq_cfg_i (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .events(ev),
		.auto_light_control_enable(auto), .main_sensor_level(ml),
		.second_sensor_level(sl), .host_irq_q(irq), .light_source_select_q(sel),
		.second_sensor_enable_q(sen), .sixth_led_sink_off_q(sink),
		.brightness_level_q(lvl), .backlight_off_q(boff));
	blc_host blc_host_i (.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(sda_pull));
	// compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// read a register and compare
	task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp, input string what);
		logic [7:0] v;
		blc_host_i.rd_reg(p, v);
		check(what, v, exp);
	endtask : rd_chk
	// one-cycle event pulse, then let the flag land
	task automatic pulse(input int i);
		ev = blc_event_s'(5'h01 << i);
		@(posedge clk);
		#1;
		ev = '0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse
	// every mapped register plus one unmapped pointer
	localparam logic [7:0] OFS_LIST [4] = '{OFS_EVENT_STATUS, OFS_EVENT_IRQ_MASK,
		OFS_BACKLIGHT_CFG, 8'h07};
	// reset values, unmapped pointer reads zero
	task automatic t_reset();
		check("irq", irq, 8'h00);
		for (int k = 0; k < 4; k++) begin
			rd_chk(OFS_LIST[k], 8'h00, "reset");
		end
	endtask : t_reset
	// each event: flag held while masked, irq per mask bit, clear by writing one
	task automatic t_events();
		blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, 8'h20);
		for (int i = 0; i < EVENT_W; i++) begin
			blc_host_i.wr_reg(OFS_EVENT_IRQ_MASK, ~(8'h01 << i));
			pulse(i);
			check("irq masked", irq, 8'h00);
			rd_chk(OFS_EVENT_STATUS, 8'h01 << i, "flag held");
			rd_chk(OFS_EVENT_IRQ_MASK, 8'h1f & ~(8'h01 << i), "mask");
			blc_host_i.wr_reg(OFS_EVENT_IRQ_MASK, 8'h01 << i);
			check("irq", irq, 8'h01);
			blc_host_i.wr_reg(OFS_EVENT_STATUS, ~(8'h01 << i));
			rd_chk(OFS_EVENT_STATUS, 8'h01 << i, "flag kept");
			blc_host_i.wr_reg(OFS_EVENT_STATUS, 8'h01 << i);
			check("irq cleared", irq, 8'h00);
		end
		blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, 8'h00);
		pulse(BIT_SECOND_LIGHT);
		rd_chk(OFS_EVENT_STATUS, 8'h00, "second off");
	endtask : t_events
	// every level code with select and enable varied apart
	task automatic t_cfg();
		logic [7:0] v;
		for (int l = 0; l < 4; l++) begin
			v = 8'h87 | 8'(l << 3) | {1'b0, l[0], l[1], 5'h00};
			blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, v);
			check("select", sel, l[0]);
			check("sensor en", sen, l[1]);
			check("sink off", sink, l[1]);
			check("level", lvl, l[1:0]);
			check("off", boff, l == 3);
			rd_chk(OFS_BACKLIGHT_CFG, v & 8'h7f, "cfg");
		end
	endtask : t_cfg
	// automatic control overrides host level writes
	task automatic t_auto();
		ml = 2'h2;
		sl = 2'h1;
		blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, 8'h00);
		auto = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("auto level", lvl, 8'h02);
		blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, 8'h18);
		check("auto kept", lvl, 8'h02);
		blc_host_i.wr_reg(OFS_BACKLIGHT_CFG, 8'h40);
		rd_chk(OFS_BACKLIGHT_CFG, 8'h48, "auto report");
		auto = 1'b0;
	endtask : t_auto
	// foreign address ignored, burst write and acked burst read walk the pointer
	task automatic t_port();
		logic [7:0] q, v1, v2;
		logic a0, a1, a2, a3;
		blc_host_i.start();
		blc_host_i.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a0);
		blc_host_i.xfer(OFS_BACKLIGHT_CFG, 1'b1, q, a1);
		blc_host_i.xfer(8'h00, 1'b1, q, a2);
		blc_host_i.stop();
		check("foreign nack", {6'h00, a0, a1}, 8'h03);
		check("foreign ignored", sel, 8'h01);
		blc_host_i.start();
		blc_host_i.xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
		blc_host_i.xfer(OFS_EVENT_IRQ_MASK, 1'b1, q, a1);
		blc_host_i.xfer(8'h1f, 1'b1, q, a2);
		blc_host_i.xfer(8'h30, 1'b1, q, a3);
		blc_host_i.stop();
		check("burst acks", {4'h0, a0, a1, a2, a3}, 8'h00);
		check("burst sink", sink, 8'h01);
		check("burst level", lvl, 8'h02);
		blc_host_i.start();
		blc_host_i.xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
		blc_host_i.xfer(OFS_EVENT_IRQ_MASK, 1'b1, q, a1);
		blc_host_i.start();
		blc_host_i.xfer({DEV_ADDR, 1'b1}, 1'b1, q, a2);
		blc_host_i.xfer(8'hff, 1'b0, v1, a3);
		blc_host_i.xfer(8'hff, 1'b1, v2, a3);
		blc_host_i.stop();
		check("read acks", {5'h00, a0, a1, a2}, 8'h00);
		check("burst mask", v1, 8'h1f);
		check("burst cfg", v2, 8'h30);
	endtask : t_port
	// verdict and end of run
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_events();
		t_cfg();
		t_auto();
		t_port();
		check("acks", 8'(blc_host_i.nacks), 8'h00);
		summarize();
	end
endmodule : blc_fault_irq_cfg_test
